/* File: include/uam_params.svh */
/*
 * Constants of the serial address-match receiver: register offsets, field
 * positions, reset values and timing counts.
 * Assumes it is included by its bare name from the package and the core.
 */
`ifndef UAM_PARAMS_SVH
`define UAM_PARAMS_SVH

// ****************************************************************
// Register byte offsets on APB
// ****************************************************************
`define UAM_OFS_CONTROL   8'h00
`define UAM_OFS_ADDRESS   8'h04
`define UAM_OFS_ADDR_MASK 8'h08
`define UAM_OFS_STATUS    8'h0C
`define UAM_OFS_INT_MASK  8'h10
`define UAM_OFS_RX_DATA   8'h14
`define UAM_OFS_BAUD_DIV  8'h18

// ****************************************************************
// Field positions
// ****************************************************************
`define UAM_CTL_MODE_LSB  0
`define UAM_CTL_MODE_MSB  1
`define UAM_CTL_FILTER    2
`define UAM_CTL_RX_EN     3
`define UAM_ST_RX_FLAG    0
`define UAM_ST_REJECT     1
`define UAM_DATA_NINTH    8

// ****************************************************************
// Reset values
// ****************************************************************
`define UAM_RST_CONTROL   4'h0
`define UAM_RST_ADDRESS   8'h00
`define UAM_RST_ADDR_MASK 8'h00
`define UAM_RST_INT_MASK  2'h0
`define UAM_RST_BAUD_DIV  16'h000A

// ****************************************************************
// Timing: clock rate, oversampling and sample point per bit
// ****************************************************************
`define UAM_CLK_HZ        20000000
`define UAM_OVERSAMPLE    4'hF
`define UAM_SAMPLE_PT     4'h7

`endif

/* File: include/uam_pkg.sv */
/*
 * Types shared by the serial address-match receiver.
 * Assumes uam_params.svh sits on the include path.
 */
`include "uam_params.svh"

package uam_pkg;

    // ****************************************************************
    // Serial modes and control word
    // ****************************************************************
    typedef enum logic [1:0] {
        UAM_MODE_SHIFT,
        UAM_MODE_ASYNC8,
        UAM_MODE_ASYNC9A,
        UAM_MODE_ASYNC9B
    } uam_mode_t;

    typedef struct packed {
        logic      rxEnable;
        logic      filterBit;
        uam_mode_t mode;
    } uam_ctrl_t;

    // Receiver sequencer
    typedef enum logic [2:0] {
        UAM_RX_IDLE,
        UAM_RX_START,
        UAM_RX_BITS,
        UAM_RX_STOP,
        UAM_RX_SHIFT
    } uam_rx_state_t;

    // Received frame: eight data bits plus ninth or stop bit
    typedef struct packed {
        logic       ninth;
        logic [7:0] data;
    } uam_frame_t;

endpackage

/* File: core/uam_core.sv */
/*
 * Serial receiver with address recognition for a multidrop link, plus its
 * APB register file and a level interrupt.
 * Assumes a single 20 MHz clock, rxd arriving asynchronously from the line,
 * and an APB master that holds each request until pready.
 */
`include "uam_params.svh"

// Notes on behaviour
// R01: Filtered 9-bit address flagged only on match
// R02: Ninth bit one means address, zero data
// R03: Software clears filter bit to take data
// R04: 8-bit mode: stop bit stands for ninth
// R05: Shift mode ignores the filter bit
// R06: Mask zero bits are don't-care in given
// R07: Broadcast is address OR mask, zeros ignored
// R08: Reset zeroes address and mask, all match
// R09: Address F1 mask FA takes F0, F1, F4, F5
// R10: Async start only while receive enable set
// R11: Rejected frames leave RX flag clear, set reject bit
// R12: Compare only eight data bits
module uam_core
    import uam_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rxd,
    output logic             shiftClk,
    output logic             irq
);

    // ****************************************************************
    // Functions
    // ****************************************************************
    // Given address: only bits with mask one must equal the stored bit
    function automatic logic givenMatch(input logic [7:0] rx, input logic [7:0] adr, input logic [7:0] msk);
        givenMatch = (((rx ^ adr) & msk) == 8'h00);
    endfunction
    // Broadcast: OR of address and mask, zero bits ignored
    function automatic logic broadcastMatch(input logic [7:0] rx, input logic [7:0] adr, input logic [7:0] msk);
        logic [7:0] bc;
        bc = adr | msk;
        broadcastMatch = (((rx ^ bc) & bc) == 8'h00);
    endfunction

    // ****************************************************************
    // Reset release and line synchroniser
    // ****************************************************************
    logic rstMeta_q;
    logic rstN_q;
    logic rxMeta_q;
    logic rxSync_q;
    logic rxPrev_q;

    // Reset is asserted at once but released through two flops
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_q <= 1'b0;
            rstN_q    <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstN_q    <= rstMeta_q;
        end
    end

    // Line idles high; first flop feeds only the second
    always_ff @(posedge clk_sys or negedge rstN_q) begin
        if (!rstN_q) begin
            rxMeta_q <= 1'b1;
            rxSync_q <= 1'b1;
            rxPrev_q <= 1'b1;
        end else begin
            rxMeta_q <= rxd;
            rxSync_q <= rxMeta_q;
            rxPrev_q <= rxSync_q;
        end
    end

    // ****************************************************************
    // Register state
    // ****************************************************************
    uam_ctrl_t   ctl_q, ctl_d;
    logic [7:0]  addr_q, addr_d;
    logic [7:0]  mask_q, mask_d;
    logic [1:0]  status_q, status_d;
    logic [1:0]  intMask_q, intMask_d;
    logic [15:0] baudDiv_q, baudDiv_d;
    uam_frame_t  rxData_q, rxData_d;
    logic [31:0] prdata_q, prdata_d;
    logic        pready_q, pready_d;
    logic        pslverr_q, pslverr_d;
    logic        irq_q, irq_d;

    // ****************************************************************
    // Receiver state
    // ****************************************************************
    uam_rx_state_t rxState_q, rxState_d;
    logic [15:0]   baudCnt_q, baudCnt_d;
    logic [3:0]    phase_q, phase_d;
    logic [3:0]    bitIdx_q, bitIdx_d;
    logic [8:0]    shift_q, shift_d;
    logic          shiftClk_q, shiftClk_d;
    logic          frameDone;
    logic          frameAccept;
    uam_frame_t    frame;
    logic          tick;
    logic          sampleNow;
    logic          bitEnd;
    logic          filterOn;
    logic          addrHit;
    logic [3:0]    lastBit;
    // ****************************************************************
    // Receiver sequencer
    // ****************************************************************
    // Tick every divisor plus one clocks, sixteen ticks a bit; zero ticks each clock
    always_comb begin
        tick      = (baudCnt_q == 16'h0000);
        baudCnt_d = tick ? baudDiv_q : baudCnt_q - 16'h0001;
    end
    assign sampleNow = tick && (phase_q == `UAM_SAMPLE_PT);
    assign bitEnd    = tick && (phase_q == `UAM_OVERSAMPLE);
    assign lastBit   = (ctl_q.mode == UAM_MODE_ASYNC8) ? 4'h7 : 4'h8;
    // R05: filter bit only counts outside shift mode
    assign filterOn  = ctl_q.filterBit && (ctl_q.mode != UAM_MODE_SHIFT);
    always_comb begin
        rxState_d   = rxState_q;
        phase_d     = tick ? phase_q + 4'h1 : phase_q;
        bitIdx_d    = bitIdx_q;
        shift_d     = shift_q;
        shiftClk_d  = 1'b1;
        frameDone   = 1'b0;
        frameAccept = 1'b0;
        frame       = '0;
        addrHit     = 1'b0;
        unique case (rxState_q)
            UAM_RX_IDLE: begin
                phase_d  = 4'h0;
                bitIdx_d = 4'h0;
                // R10: start bit honoured only with receive enabled
                if (ctl_q.rxEnable && ctl_q.mode != UAM_MODE_SHIFT && rxPrev_q && !rxSync_q) begin
                    rxState_d = UAM_RX_START;
                end else if (ctl_q.rxEnable && ctl_q.mode == UAM_MODE_SHIFT && !status_q[`UAM_ST_RX_FLAG]) begin
                    rxState_d = UAM_RX_SHIFT;
                end
            end
            UAM_RX_START: begin
                // A start bit gone high by mid-bit is a glitch
                if (sampleNow && rxSync_q) begin
                    rxState_d = UAM_RX_IDLE;
                end else if (bitEnd) begin
                    rxState_d = UAM_RX_BITS;
                end
            end
            UAM_RX_BITS: begin
                // LSB first; eight-bit frames end up in the upper bits
                if (sampleNow) begin
                    shift_d = {rxSync_q, shift_q[8:1]};
                end
                if (bitEnd) begin
                    bitIdx_d = bitIdx_q + 4'h1;
                    if (bitIdx_q == lastBit) begin
                        rxState_d = UAM_RX_STOP;
                    end
                end
            end
            UAM_RX_STOP: begin
                if (sampleNow) begin
                    frameDone = 1'b1;
                    rxState_d = UAM_RX_IDLE;
                    if (ctl_q.mode == UAM_MODE_ASYNC8) begin
                        // R04: stop bit takes the place of the ninth
                        frame = {rxSync_q, shift_q[8:1]};
                    end else begin
                        // R02: ninth bit marks address against data
                        frame = {shift_q[8], shift_q[7:0]};
                    end
                    // R12: eight data bits only in the compare
                    // R06: given address under mask
                    // R07: broadcast address
                    // R09: F1 under FA takes F0, F1, F4, F5
                    addrHit = givenMatch(frame.data, addr_q, mask_q) || broadcastMatch(frame.data, addr_q, mask_q);
                    // R01: filtered frame needs address bit and a hit
                    // R11: anything else is dropped, setting only the reject bit
                    frameAccept = !filterOn || (frame.ninth && addrHit);
                end
            end
            UAM_RX_SHIFT: begin
                // Clock low for the first half of each bit, sampled at bit end just before the fall
                shiftClk_d = (phase_q > `UAM_SAMPLE_PT);
                if (bitEnd) begin
                    shift_d  = {1'b0, rxSync_q, shift_q[7:1]};
                    bitIdx_d = bitIdx_q + 4'h1;
                    if (bitIdx_q == 4'h7) begin
                        // R05: shift-mode frames are always taken
                        frameDone   = 1'b1;
                        frameAccept = 1'b1;
                        frame       = {1'b0, rxSync_q, shift_q[7:1]};
                        rxState_d   = UAM_RX_IDLE;
                    end
                end
                if (!ctl_q.rxEnable || ctl_q.mode != UAM_MODE_SHIFT) begin
                    rxState_d = UAM_RX_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstN_q) begin
        if (!rstN_q) begin
            rxState_q  <= UAM_RX_IDLE;
            baudCnt_q  <= 16'h0000;
            phase_q    <= 4'h0;
            bitIdx_q   <= 4'h0;
            shift_q    <= 9'h000;
            shiftClk_q <= 1'b1;
        end else begin
            rxState_q  <= rxState_d;
            baudCnt_q  <= baudCnt_d;
            phase_q    <= phase_d;
            bitIdx_q   <= bitIdx_d;
            shift_q    <= shift_d;
            shiftClk_q <= shiftClk_d;
        end
    end

    // ****************************************************************
    // APB register file
    // ****************************************************************
    logic setup;
    logic access;
    logic mapped;
    assign setup  = psel && !penable;
    assign access = psel && penable && pready_q;
    assign mapped = (paddr == `UAM_OFS_CONTROL) || (paddr == `UAM_OFS_ADDRESS)
                    || (paddr == `UAM_OFS_ADDR_MASK) || (paddr == `UAM_OFS_STATUS)
                    || (paddr == `UAM_OFS_INT_MASK) || (paddr == `UAM_OFS_RX_DATA)
                    || (paddr == `UAM_OFS_BAUD_DIV);
    // Answer is given in the first access cycle; data latched at setup
    always_comb begin
        ctl_d     = ctl_q;
        addr_d    = addr_q;
        mask_d    = mask_q;
        intMask_d = intMask_q;
        baudDiv_d = baudDiv_q;
        rxData_d  = rxData_q;
        status_d  = status_q;
        pready_d  = setup;
        pslverr_d = setup && !mapped;
        prdata_d  = 32'h0000_0000;
        if (setup && !pwrite) begin
            unique case (paddr)
                `UAM_OFS_CONTROL:   prdata_d[3:0]  = ctl_q;
                `UAM_OFS_ADDRESS:   prdata_d[7:0]  = addr_q;
                `UAM_OFS_ADDR_MASK: prdata_d[7:0]  = mask_q;
                `UAM_OFS_STATUS:    prdata_d[1:0]  = status_q;
                `UAM_OFS_INT_MASK:  prdata_d[1:0]  = intMask_q;
                `UAM_OFS_RX_DATA:   prdata_d[8:0]  = rxData_q;
                `UAM_OFS_BAUD_DIV:  prdata_d[15:0] = baudDiv_q;
                default:            prdata_d       = 32'h0000_0000;
            endcase
        end
        if (access && pwrite) begin
            unique case (paddr)
                `UAM_OFS_CONTROL: begin
                    // R03: software drops the filter bit to take data frames
                    ctl_d.mode      = uam_mode_t'(pwdata[`UAM_CTL_MODE_MSB:`UAM_CTL_MODE_LSB]);
                    ctl_d.filterBit = pwdata[`UAM_CTL_FILTER];
                    ctl_d.rxEnable  = pwdata[`UAM_CTL_RX_EN];
                end
                `UAM_OFS_ADDRESS:   addr_d    = pwdata[7:0];
                `UAM_OFS_ADDR_MASK: mask_d    = pwdata[7:0];
                `UAM_OFS_STATUS:    status_d  = status_q & ~pwdata[1:0];
                `UAM_OFS_INT_MASK:  intMask_d = pwdata[1:0];
                `UAM_OFS_BAUD_DIV:  baudDiv_d = pwdata[15:0];
                default:            status_d  = status_q;
            endcase
        end
        // Hardware events win over a clear in the same cycle
        if (frameDone && frameAccept) begin
            status_d[`UAM_ST_RX_FLAG] = 1'b1;
            rxData_d                  = frame;
        end
        // R11: a rejected frame only raises the reject event
        if (frameDone && !frameAccept) begin
            status_d[`UAM_ST_REJECT] = 1'b1;
        end
        irq_d = |(status_d & intMask_d);
    end

    // R08: address and mask reset to zero, so every address matches
    always_ff @(posedge clk_sys or negedge rstN_q) begin
        if (!rstN_q) begin
            ctl_q     <= `UAM_RST_CONTROL;
            addr_q    <= `UAM_RST_ADDRESS;
            mask_q    <= `UAM_RST_ADDR_MASK;
            intMask_q <= `UAM_RST_INT_MASK;
            baudDiv_q <= `UAM_RST_BAUD_DIV;
            status_q  <= 2'h0;
            rxData_q  <= '0;
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            irq_q     <= 1'b0;
        end else begin
            ctl_q     <= ctl_d;
            addr_q    <= addr_d;
            mask_q    <= mask_d;
            intMask_q <= intMask_d;
            baudDiv_q <= baudDiv_d;
            status_q  <= status_d;
            rxData_q  <= rxData_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            irq_q     <= irq_d;
        end
    end

    // ****************************************************************
    // Outputs, all straight from flops
    // ****************************************************************
    assign prdata   = prdata_q;
    assign pready   = pready_q;
    assign pslverr  = pslverr_q;
    assign shiftClk = shiftClk_q;
    assign irq      = irq_q;

endmodule

/* File: tb/uam_core_props.sv */
/* Checker on the receiver core ports: APB replies, register widths, irq.
   Assumes it is bound to uam_core. */
module uam_core_props (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************
    // Port relations
    // ****************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // Setup phase, then completed access
    sequence apbSetup;
        psel && !penable;
    endsequence
    sequence apbDone;
        psel && penable && pready;
    endsequence

    a_ready_after_setup: assert property (apbSetup |=> pready)
        else $error("no pready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    a_error_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr alone");
    a_unmapped_error: assert property (apbDone ##0 (paddr > 8'h18) |-> pslverr)
        else $error("unmapped not refused");
    a_mapped_no_error: assert property (apbDone ##0 (paddr <= 8'h18 && paddr[1:0] == 2'b00) |-> !pslverr)
        else $error("mapped refused");
    a_error_reads_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read not zero");
    a_address_byte_wide: assert property (apbDone ##0 (!pwrite && paddr inside {8'h04, 8'h08})
        |-> prdata[31:8] == 24'h0)
        else $error("address register too wide");
    a_irq_low_reset: assert property ($rose(rst_n) |-> !irq)
        else $error("irq set after reset");
    // Only a status clear or mask write can drop the line
    a_irq_falls_write: assert property ($fell(irq) |-> $past(psel && penable && pwrite, 1))
        else $error("irq fell without write");
endmodule

bind uam_core uam_core_props uam_core_props_i (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));

/* File: tb/uam_master_model.sv */
/* Serial master on the multidrop line, driving rxd.
   Assumes a baud divisor of zero: sixteen clocks a bit. */
module uam_master_model (
    input  wire logic clk_sys,
    input  wire logic shiftClk,
    output logic      rxd
);
    timeunit 1ns;
    timeprecision 1ns;
    // *****************
    // Frame generation
    // *****************
    localparam int BitClks = 16;

    // Line rests high on its pull-up
    initial rxd = 1'b1;

    task automatic putBit(input logic b);
        rxd <= b;
        repeat (BitClks) @(posedge clk_sys);
    endtask

    // Start, eight bits LSB first, optional ninth bit, stop
    task automatic sendFrame(input logic [7:0] dat, input logic ext, input logic nine);
        @(posedge clk_sys);
        putBit(1'b0);
        for (int i = 0; i < 8; i++) begin
            putBit(dat[i]);
        end
        if (nine) begin
            putBit(ext);
        end
        putBit(nine | ext);
        rxd <= 1'b1;
    endtask

    // Shift mode: next bit after each fall of the bit clock
    task automatic shiftByte(input logic [7:0] dat);
        for (int i = 0; i < 8; i++) begin
            @(negedge shiftClk);
            rxd <= dat[i];
        end
    endtask

    task automatic idleLine();
        rxd <= 1'b1;
    endtask
endmodule

/* File: tb/tb_top.sv */
/* Bench for the address-match receiver: APB tasks, serial master on rxd,
   frame tables. Assumes package, header and model are compiled first. */
`include "uam_params.svh"

module tb_top
    import uam_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // *****************
    // Signals and parts
    // *****************
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rxd;
    logic        shiftClk;
    logic        irq;
    logic [31:0] rd;
    logic        err;
    logic        nineBits = 1'b1;
    int          num_errors = 0;
    int          total_checks = 0;
    int          cycles = 0;
    int          n;
    // Each entry: expected status, ninth or stop bit, address byte
    logic [10:0] t9[8] = '{11'h3F0, 11'h3F1, 11'h3F4, 11'h5F8, 11'h5F3, 11'h3FF, 11'h3FB, 11'h4F1};
    logic [10:0] t8[4] = '{11'h3F1, 11'h4F1, 11'h5F8, 11'h3FF};

    uam_core uam_core_i (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rxd(rxd), .shiftClk(shiftClk), .irq(irq));
    uam_master_model uam_master_model_i (.clk_sys(clk_sys), .shiftClk(shiftClk), .rxd(rxd));

    always #25 clk_sys = ~clk_sys;

    // Hang guard, far above the few thousand cycles needed
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // One transfer; request held until pready is sampled high
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k = 0;
        @(posedge clk_sys);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            k++;
        end while (pready !== 1'b1 && k < 16);
        check({31'h0, pready}, 32'h1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0);
        check(rd, exp);
    endtask

    function automatic logic [31:0] ctl(input logic en, input logic flt, input uam_mode_t m);
        uam_ctrl_t c;
        c = '{rxEnable: en, filterBit: flt, mode: m};
        return {28'h0, c};
    endfunction

    // Frame in, then status, irq and, for a taken frame, data compared, status cleared
    task automatic frame(input logic [10:0] f);
        uam_master_model_i.sendFrame(f[7:0], f[8], nineBits);
        repeat (4) @(posedge clk_sys);
        rdChk(`UAM_OFS_STATUS, {30'h0, f[10:9]});
        check({31'h0, irq}, {31'h0, f[9]});
        if (f[9]) begin
            rdChk(`UAM_OFS_RX_DATA, {23'h0, f[8:0]});
        end
        apb(`UAM_OFS_STATUS, 1'b1, 32'h3);
    endtask

    // *****************
    // Test sequence
    // *****************
    initial begin
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rdChk(`UAM_OFS_ADDRESS, 32'h0);
        rdChk(`UAM_OFS_ADDR_MASK, 32'h0);
        rdChk(`UAM_OFS_BAUD_DIV, 32'h0000000A);
        rdChk(8'h1C, 32'h0);
        check({31'h0, err}, 32'h1);
        apb(`UAM_OFS_BAUD_DIV, 1'b1, 32'h0);
        apb(`UAM_OFS_INT_MASK, 1'b1, 32'h1);
        // Cleared address and mask let any address in
        apb(`UAM_OFS_CONTROL, 1'b1, ctl(1'b1, 1'b1, UAM_MODE_ASYNC9A));
        frame(11'h35A);
        // Masked flag keeps irq low until unmasked
        uam_master_model_i.sendFrame(8'h33, 1'b1, 1'b1);
        apb(`UAM_OFS_INT_MASK, 1'b1, 32'h0);
        repeat (2) @(posedge clk_sys);
        check({31'h0, irq}, 32'h0);
        apb(`UAM_OFS_INT_MASK, 1'b1, 32'h1);
        repeat (2) @(posedge clk_sys);
        check({31'h0, irq}, 32'h1);
        apb(`UAM_OFS_STATUS, 1'b1, 32'h1);
        repeat (2) @(posedge clk_sys);
        check({31'h0, irq}, 32'h0);
        // Given and broadcast matching, address F1 mask FA
        apb(`UAM_OFS_ADDRESS, 1'b1, 32'hF1);
        apb(`UAM_OFS_ADDR_MASK, 1'b1, 32'hFA);
        foreach (t9[i]) begin
            frame(t9[i]);
        end
        apb(`UAM_OFS_CONTROL, 1'b1, ctl(1'b1, 1'b1, UAM_MODE_ASYNC9B));
        frame(11'h4F1);
        // addressed slave drops the filter for data
        apb(`UAM_OFS_CONTROL, 1'b1, ctl(1'b1, 1'b0, UAM_MODE_ASYNC9B));
        frame(11'h242);
        nineBits = 1'b0;
        apb(`UAM_OFS_CONTROL, 1'b1, ctl(1'b1, 1'b1, UAM_MODE_ASYNC8));
        foreach (t8[i]) begin
            frame(t8[i]);
        end
        nineBits = 1'b1;
        apb(`UAM_OFS_CONTROL, 1'b1, ctl(1'b0, 1'b1, UAM_MODE_ASYNC9A));
        frame(11'h1F1);
        // Shift mode takes 35 though it fails the match
        fork
            uam_master_model_i.shiftByte(8'h35);
            apb(`UAM_OFS_CONTROL, 1'b1, ctl(1'b1, 1'b1, UAM_MODE_SHIFT));
        join
        n = 0;
        do begin
            apb(`UAM_OFS_STATUS, 1'b0, 32'h0);
            n++;
        end while (rd[0] !== 1'b1 && n < 200);
        check(rd, 32'h1);
        apb(`UAM_OFS_RX_DATA, 1'b0, 32'h0);
        check({24'h0, rd[7:0]}, 32'h35);
        apb(`UAM_OFS_CONTROL, 1'b1, 32'h0);
        uam_master_model_i.idleLine();
        results();
    end
endmodule
